// >>> hdl/obdc_output_bank_d_control.sv
// register file and pin/register setting select for output bank d
`timescale 1ns/1ps
module obdc_output_bank_d_control
    import obdc_pkg::*;
#(
    // widths of the switched divider fields
    parameter int INT_DIV_W = OBDC_INTDIV_W,
    parameter int FRAC_W    = OBDC_FRAC_W,
    parameter int FINT_W    = OBDC_FINT_W
)
(
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    output logic                      wb_err_o,
    // bank control pins, asynchronous
    input  wire logic [1:0]           bankCtrlPins,
    // effective bank settings
    output logic                      bankPowerDown,
    output logic                      firstOutputEnable,
    output logic                      secondOutputEnable,
    output logic                      firstOutputStyle,
    output logic      [1:0]           firstOutputAmplitude,
    output logic                      dividerTypeSelect,
    output logic                      dividerSourceSelect,
    output logic      [1:0]           fractionalPostDivide,
    output logic      [INT_DIV_W-1:0] integerDivideValue,
    output logic      [FRAC_W-1:0]    fractionalPart,
    output logic      [FINT_W-1:0]    fractionalIntegerPart
);
    // the pin code fills the two low divide bits, and the integer and
    // fractional-integer fields share the one divide register
    if (INT_DIV_W < 2 || INT_DIV_W > OBDC_BIT_FINT || FINT_W < 1 ||
        OBDC_BIT_FINT + FINT_W > 32 || FRAC_W < 1 || FRAC_W > 32) begin
        $error("unsupported divider field width");
    end

    // pin synchroniser
    logic [1:0] pinMeta_q, pinSync_q;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pinMeta_q <= 2'h0;
            pinSync_q <= 2'h0;
        end else begin
            pinMeta_q <= bankCtrlPins;
            pinSync_q <= pinMeta_q;
        end
    end

    // registers and bus answer
    logic [31:0] ctrl_q, ctrl_d, div_q, div_d, frac_q, frac_d;
    logic [31:0] rdat_d;
    logic        ack_q, ack_d, err_q, err_d;
    logic        req;
    logic        hit;
    logic [31:0] statusWord;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wdat,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = wdat[i*8 +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        // the pending answer blocks a held request from being taken twice
        req    = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
        ctrl_d = ctrl_q;
        div_d  = div_q;
        frac_d = frac_q;
        rdat_d = 32'h0;
        hit    = 1'b1;
        unique case (wb_adr_i)
            OBDC_ADDR_CTRL: begin
                rdat_d = ctrl_q;
                if (req && wb_we_i) begin
                    ctrl_d = merge(ctrl_q, wb_dat_i, wb_sel_i);
                end
            end
            OBDC_ADDR_DIV: begin
                rdat_d = div_q;
                if (req && wb_we_i) begin
                    div_d = merge(div_q, wb_dat_i, wb_sel_i);
                end
            end
            OBDC_ADDR_FRAC: begin
                rdat_d = frac_q;
                if (req && wb_we_i) begin
                    frac_d = merge(frac_q, wb_dat_i, wb_sel_i);
                end
            end
            OBDC_ADDR_STATUS: begin
                rdat_d = statusWord;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        // reserved bits are stored as written; software keeps them zero
        ack_d = req && hit;
        err_d = req && !hit;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_q   <= OBDC_RST_CTRL;
            div_q    <= OBDC_RST_DIV;
            frac_q   <= OBDC_RST_FRAC;
            ack_q    <= 1'b0;
            err_q    <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            ctrl_q   <= ctrl_d;
            div_q    <= div_d;
            frac_q   <= frac_d;
            ack_q    <= ack_d;
            err_q    <= err_d;
            wb_dat_o <= (req && !wb_we_i) ? rdat_d : 32'h0;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;

    // setting select: pins or registers
    logic        selBankPd, selPairPd, selStyle, selDivType, selDivSrc;
    logic [1:0]  selAmp, selPost;
    logic [INT_DIV_W-1:0] selIntDiv;
    logic [FRAC_W-1:0]    selFrac;
    logic [FINT_W-1:0]    selFint;
    logic        cfgFromRegs;

    always_comb begin
        cfgFromRegs = ctrl_q[OBDC_BIT_CFG_SRC];
        if (cfgFromRegs) begin
            selBankPd  = ctrl_q[OBDC_BIT_BANK_PD];
            selPairPd  = ctrl_q[OBDC_BIT_PAIR_PD];
            selStyle   = ctrl_q[OBDC_BIT_STYLE];
            selAmp     = ctrl_q[OBDC_BIT_AMP_LO +: 2];
            selDivType = ctrl_q[OBDC_BIT_DIV_TYPE];
            selDivSrc  = ctrl_q[OBDC_BIT_DIV_SRC];
            selPost    = ctrl_q[OBDC_BIT_POSTDIV +: 2];
            selIntDiv  = div_q[OBDC_BIT_INTDIV +: INT_DIV_W];
            selFint    = div_q[OBDC_BIT_FINT +: FINT_W];
            selFrac    = frac_q[FRAC_W-1:0];
        end else begin
            // pin code picks the integer divide; everything else default
            selBankPd  = 1'b0;
            selPairPd  = 1'b0;
            selStyle   = 1'b0;
            selAmp     = OBDC_AMP_350MV;
            selDivType = 1'b0;
            selDivSrc  = 1'b0;
            selPost    = OBDC_POST_DIV1;
            selIntDiv  = '0;
            selIntDiv[1:0] = pinSync_q;
            selFint    = '0;
            selFrac    = '0;
        end
    end

    // registered effective settings
    // a pin change shows here three edges later, behind the synchroniser
    always_ff @(posedge core_clk) begin
        if (reset) begin
            bankPowerDown         <= 1'b0;
            firstOutputEnable     <= 1'b1;
            secondOutputEnable    <= 1'b1;
            firstOutputStyle      <= 1'b0;
            firstOutputAmplitude  <= OBDC_AMP_350MV;
            dividerTypeSelect     <= 1'b0;
            dividerSourceSelect   <= 1'b0;
            fractionalPostDivide  <= OBDC_POST_DIV1;
            integerDivideValue    <= '0;
            fractionalPart        <= '0;
            fractionalIntegerPart <= '0;
        end else begin
            bankPowerDown         <= selBankPd;
            firstOutputEnable     <= !selBankPd && !selPairPd;
            secondOutputEnable    <= !selBankPd && !selPairPd;
            firstOutputStyle      <= selStyle;
            firstOutputAmplitude  <= selAmp;
            dividerTypeSelect     <= selDivType;
            dividerSourceSelect   <= selDivSrc;
            fractionalPostDivide  <= selPost;
            integerDivideValue    <= selIntDiv;
            fractionalPart        <= selFrac;
            fractionalIntegerPart <= selFint;
        end
    end

    // status: effective state for software
    assign statusWord = {20'h0, pinSync_q, secondOutputEnable,
                         firstOutputEnable, 7'h0, bankPowerDown};
endmodule

// >>> shared/obdc_pkg.sv
// constants for the output bank d control block
package obdc_pkg;
    // register byte offsets
    localparam logic [7:0] OBDC_ADDR_CTRL   = 8'h00;
    localparam logic [7:0] OBDC_ADDR_DIV    = 8'h04;
    localparam logic [7:0] OBDC_ADDR_FRAC   = 8'h08;
    localparam logic [7:0] OBDC_ADDR_STATUS = 8'h0c;
    // control register field positions
    localparam int OBDC_BIT_BANK_PD   = 0;
    localparam int OBDC_BIT_CFG_SRC   = 1;
    localparam int OBDC_BIT_PAIR_PD   = 2;
    localparam int OBDC_BIT_STYLE     = 3;
    localparam int OBDC_BIT_AMP_LO    = 4;
    localparam int OBDC_BIT_DIV_TYPE  = 6;
    localparam int OBDC_BIT_DIV_SRC   = 7;
    localparam int OBDC_BIT_POSTDIV   = 8;
    // divide register field positions
    localparam int OBDC_BIT_INTDIV    = 0;
    localparam int OBDC_BIT_FINT      = 8;
    // widths
    localparam int OBDC_INTDIV_W  = 6;
    localparam int OBDC_FRAC_W    = 24;
    localparam int OBDC_FINT_W    = 4;
    // reset values
    localparam logic [31:0] OBDC_RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] OBDC_RST_DIV  = 32'h0000_0000;
    localparam logic [31:0] OBDC_RST_FRAC = 32'h0000_0000;
    // amplitude and post-divide codes
    localparam logic [1:0] OBDC_AMP_350MV = 2'h0;
    localparam logic [1:0] OBDC_AMP_500MV = 2'h1;
    localparam logic [1:0] OBDC_AMP_750MV = 2'h2;
    localparam logic [1:0] OBDC_POST_DIV1 = 2'h0;
    localparam logic [1:0] OBDC_POST_DIV2 = 2'h1;
    localparam logic [1:0] OBDC_POST_DIV4 = 2'h2;
endpackage

// >>> verification/obdc_monitor.sv
// port assertions for the output bank d control block
`timescale 1ns/1ps
module obdc_monitor (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        reset,
    // bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    // bank state
    input wire logic        bankPowerDown,
    input wire logic        firstOutputEnable,
    input wire logic        secondOutputEnable
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    wire logic req = wb_cyc_i && wb_stb_i;
    wire logic hit = wb_adr_i inside {8'h00, 8'h04, 8'h08, 8'h0c};
    bus_answer_a: assert property (req && !wb_ack_o && !wb_err_o |=>
        wb_ack_o || wb_err_o) else $error("request not answered");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_mapped_a: assert property (wb_ack_o |-> $past(req && hit))
        else $error("ack without mapped request");
    err_unmapped_a: assert property (wb_err_o |-> $past(req && !hit))
        else $error("err without unmapped request");
    resp_excl_a: assert property (!(wb_ack_o && wb_err_o))
        else $error("ack and err together");
    read_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    bank_hiz_a: assert property (bankPowerDown |-> !secondOutputEnable)
        else $error("second output driven in bank power-down");
    pair_hiz_a: assert property (!firstOutputEnable |->
        !secondOutputEnable) else $error("second output driven");
    cover property (wb_err_o);
    cover property (bankPowerDown);
    cover property (!firstOutputEnable && !bankPowerDown);
endmodule
bind obdc_output_bank_d_control obdc_monitor mon (.*);

// >>> verification/test_obdc_output_bank_d_control.sv
// random and directed bench for the output bank d control block
`timescale 1ns/1ps
module test_obdc_output_bank_d_control;
    import obdc_pkg::*;
    logic core_clk = 0, reset = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = 8'h0;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0, q, c, d, f, lf = 32'h9c3c6648;
    logic [31:0] dato, tbl [6] = '{32'h2, 32'h6, 32'h7, 32'h1a, 32'h12a,
                                   32'h2ea};
    logic [1:0] pins = 2'h0;
    logic ack, err, e, bpd, fe, se, sty, dt, ds;
    logic [1:0] amp, pdv;
    logic [5:0] idv;
    logic [23:0] fr;
    logic [3:0] fi;
    int errCount = 0, nChecks = 0;
    obdc_output_bank_d_control uut (.core_clk(core_clk), .reset(reset),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack),
        .wb_err_o(err), .bankCtrlPins(pins), .bankPowerDown(bpd),
        .firstOutputEnable(fe), .secondOutputEnable(se),
        .firstOutputStyle(sty), .firstOutputAmplitude(amp),
        .dividerTypeSelect(dt), .dividerSourceSelect(ds),
        .fractionalPostDivide(pdv), .integerDivideValue(idv),
        .fractionalPart(fr), .fractionalIntegerPart(fi));
    wire logic [43:0] outs = {bpd, fe, se, sty, amp, dt, ds, pdv, idv, fr, fi};
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    function automatic logic [31:0] rnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // pin mode leaves everything at its power-up default except the divide
    function automatic logic [43:0] expo(input logic [31:0] c, d, f);
        logic on;
        on = !(c[OBDC_BIT_BANK_PD] | c[OBDC_BIT_PAIR_PD]);
        if (!c[OBDC_BIT_CFG_SRC]) begin
            return {1'b0, 2'b11, 7'h0, 4'h0, pins, 28'h0};
        end
        return {c[OBDC_BIT_BANK_PD], on, on, c[OBDC_BIT_STYLE],
                c[OBDC_BIT_AMP_LO +: 2], c[OBDC_BIT_DIV_TYPE],
                c[OBDC_BIT_DIV_SRC], c[OBDC_BIT_POSTDIV +: 2],
                d[OBDC_BIT_INTDIV +: 6], f[23:0], d[OBDC_BIT_FINT +: 4]};
    endfunction
    // status bits: pins at 11:10, enables at 9:8, bank power-down at 0
    function automatic logic [11:0] exps(input logic [31:0] c);
        logic [43:0] o;
        o = expo(c, 32'h0, 32'h0);
        return {pins, o[41], o[42], 7'h0, o[43]};
    endfunction
    task automatic check_word(input logic [31:0] got, want);
        nChecks++;
        if (got !== want) begin
            errCount++;
            $display("[ERR] %0t read %h want %h", $time, got, want);
        end
    endtask
    task automatic check_outs(input logic [43:0] got, want);
        nChecks++;
        if (got !== want) begin
            errCount++;
            $display("[ERR] %0t outputs %h want %h", $time, got, want);
        end
    endtask
    task automatic check_resp(input logic got, want);
        nChecks++;
        if (got !== want) begin
            errCount++;
            $display("[ERR] %0t error flag %b want %b", $time, got, want);
        end
    endtask
    // waits for the answer however long it takes; the watchdog ends a hang
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] v);
        @(posedge core_clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, v};
        do begin
            @(posedge core_clk);
        end while (ack !== 1'b1 && err !== 1'b1);
        q = dato;
        e = err;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic results();
        if (errCount == 0 && nChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        errCount++;
        results();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        c = 32'h0;
        d = 32'h0;
        f = 32'h0;
        bus(1'b0, OBDC_ADDR_CTRL, 32'h0);
        check_word(q, OBDC_RST_CTRL);
        bus(1'b0, OBDC_ADDR_DIV, 32'h0);
        check_word(q, OBDC_RST_DIV);
        bus(1'b0, OBDC_ADDR_FRAC, 32'h0);
        check_word(q, OBDC_RST_FRAC);
        bus(1'b0, OBDC_ADDR_STATUS, 32'h0);
        check_word(q & 32'hf01, {20'h0, exps(c)});
        check_outs(outs, expo(32'h0, 32'h0, 32'h0));
        for (int i = 0; i < 4; i++) begin
            lf = rnd(lf);
            pins <= lf[1:0];
            bus(1'b1, OBDC_ADDR_CTRL, lf & 32'h3fc);
            repeat (4) @(posedge core_clk);
            check_outs(outs, expo(32'h0, 32'h0, 32'h0));
        end
        for (int i = 0; i < 16; i++) begin
            lf = rnd(lf);
            d = lf & 32'hf3f;
            f = rnd(lf) & 32'hffffff;
            c = i < 6 ? tbl[i] : (lf & 32'h3fd) | 32'h2;
            if (c[0]) c[2] = 1'b1;
            if (c[5:4] == 2'h3) c[5:4] = OBDC_AMP_500MV;
            if (c[9:8] == 2'h3) c[9:8] = OBDC_POST_DIV4;
            bus(1'b1, OBDC_ADDR_DIV, d);
            bus(1'b1, OBDC_ADDR_FRAC, f);
            bus(1'b1, OBDC_ADDR_CTRL, c);
            bus(1'b0, OBDC_ADDR_CTRL, 32'h0);
            check_word(q, c);
            check_outs(outs, expo(c, d, f));
            bus(1'b1, OBDC_ADDR_STATUS, 32'hffffffff);
            bus(1'b0, OBDC_ADDR_STATUS, 32'h0);
            check_word(q & 32'hf01, {20'h0, exps(c)});
        end
        // one byte lane only: the fractional integer field alone changes
        sel <= 4'h2;
        bus(1'b1, OBDC_ADDR_DIV, 32'hffff_05ff);
        sel <= 4'hf;
        d = (d & 32'hffff_00ff) | 32'h0000_0500;
        bus(1'b0, OBDC_ADDR_DIV, 32'h0);
        check_word(q, d);
        check_outs(outs, expo(c, d, f));
        bus(1'b1, 8'h10, 32'h1);
        check_resp(e, 1'b1);
        bus(1'b0, 8'h10, 32'h0);
        check_resp(e, 1'b1);
        bus(1'b0, OBDC_ADDR_CTRL, 32'h0);
        check_resp(e, 1'b0);
        check_word(q, c);
        bus(1'b1, OBDC_ADDR_CTRL, 32'h0);
        bus(1'b0, OBDC_ADDR_DIV, 32'h0);
        check_word(q, d);
        @(posedge core_clk);
        check_outs(outs, expo(32'h0, 32'h0, 32'h0));
        // bank and pair down from registers, then a reset in mid-run
        c = 32'h2c7;
        bus(1'b1, OBDC_ADDR_CTRL, c);
        bus(1'b0, OBDC_ADDR_STATUS, 32'h0);
        check_word(q & 32'hf01, {20'h0, exps(c)});
        check_outs(outs, expo(c, d, f));
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        bus(1'b0, OBDC_ADDR_CTRL, 32'h0);
        check_word(q, OBDC_RST_CTRL);
        repeat (2) @(posedge core_clk);
        check_outs(outs, expo(32'h0, 32'h0, 32'h0));
        results();
    end
endmodule
